// >>> design/pwp_ctrl.sv
// Peripheral write-protection controller: APB4 slave, two protection groups,
// guard port for peripheral writes, event status with mask and interrupt.
// Assumes pclk at 40 MHz, presetn asynchronous active low, guard port on pclk.
//
// Implementation choice: the APB register port.
`timescale 1ns/100ps
`default_nettype none

// Overview of operation
// - Byte, halfword and word accesses complete in one access cycle.
// - Only byte lanes enabled by pstrb are updated.
// - Writing zero to a protection bit leaves its state alone.
// - One to clear side removes protection; read shows 1 when protected.
// - Group A set side at 0x04, reset zero, bits 1-6 named peripherals.
// - Group C clear side at 0x00, reset 0x00800000, bits 1-19 peripherals.
// - Writes to a protected peripheral are dropped and flagged as error.
// - One to set side protects; set and clear sides read identically.
// - Protecting twice or unprotecting twice answers with a bus error.
module pwp_ctrl
	import pwp_pkg::*;
(
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [DATA_W-1:0] pwdata,
	input  wire logic [3:0]        pstrb,
	output logic      [DATA_W-1:0] prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              guard_wr_valid,
	input  wire logic              guard_wr_group,
	input  wire logic [4:0]        guard_wr_bit,
	output logic                   guard_wr_allow,
	output logic                   guard_wr_error,
	output logic                   irq
);

	logic [31:0]       flags_a_q;
	logic [31:0]       flags_c_q;
	logic [EV_W-1:0]   ev_stat_q;
	logic [EV_W-1:0]   ev_mask_q;
	logic [DATA_W-1:0] prdata_q;
	logic              guard_err_q;
	logic [31:0]       lane_mask;
	logic [31:0]       wbits;
	logic [31:0]       wbits_a;
	logic [31:0]       wbits_c;
	pwp_reg_t          reg_sel;
	logic              wr_acc;
	logic              rd_setup;
	logic              dbl_set;
	logic              dbl_clr;
	logic              unmapped;
	logic              wr_ok;
	logic              guard_flag;
	logic [EV_W-1:0]   ev_set;
	logic [EV_W-1:0]   ev_clr;

	// Zero wait states: every access phase completes at once
	assign pready  = 1'b1;
	assign wr_acc  = psel & penable & pwrite;
	assign rd_setup = psel & ~penable & ~pwrite;

	// Expand byte strobes into a bit mask, one lane per strobe
	genvar gl;
	generate
		for (gl = 0; gl < 4; gl++) begin : g_lane
			assign lane_mask[gl*8 +: 8] = {8{pstrb[gl]}};
		end
	endgenerate

	// Only ones in enabled lanes on assigned bits act
	assign wbits   = pwdata & lane_mask;
	assign wbits_a = wbits & VALID_A;
	assign wbits_c = wbits & VALID_C;

	// Address decode; misaligned addresses count as unmapped
	always_comb begin
		if (paddr[1:0] != 2'b00) begin
			reg_sel = PWP_R_NONE;
		end else if (paddr == OFF_CLR_C) begin
			reg_sel = PWP_R_CLR_C;
		end else if (paddr == OFF_SET_A) begin
			reg_sel = PWP_R_SET_A;
		end else if (paddr == OFF_CLR_A) begin
			reg_sel = PWP_R_CLR_A;
		end else if (paddr == OFF_SET_C) begin
			reg_sel = PWP_R_SET_C;
		end else if (paddr == OFF_EV_STAT) begin
			reg_sel = PWP_R_STAT;
		end else if (paddr == OFF_EV_MASK) begin
			reg_sel = PWP_R_MASK;
		end else begin
			reg_sel = PWP_R_NONE;
		end
	end

	// Anything the decode misses, misaligned too, answers with an error
	assign unmapped = (reg_sel == PWP_R_NONE);

	// Double protect or double unprotect of any addressed bit
	always_comb begin
		dbl_set = 1'b0;
		dbl_clr = 1'b0;
		case (reg_sel)
			PWP_R_SET_A: begin
				dbl_set = |(wbits_a & flags_a_q);
			end
			PWP_R_SET_C: begin
				dbl_set = |(wbits_c & flags_c_q);
			end
			PWP_R_CLR_A: begin
				dbl_clr = |(wbits_a & ~flags_a_q);
			end
			PWP_R_CLR_C: begin
				dbl_clr = |(wbits_c & ~flags_c_q);
			end
			default: begin
				dbl_set = 1'b0;
				dbl_clr = 1'b0;
			end
		endcase
	end

	// Erroring write is dropped whole so flow checks see no partial change
	assign wr_ok   = wr_acc & ~dbl_set & ~dbl_clr & ~unmapped;
	assign pslverr = psel & penable & (unmapped | (pwrite & (dbl_set | dbl_clr)));

	// Group A protection flags
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flags_a_q <= RST_A & VALID_A;
		end else if (wr_ok && reg_sel == PWP_R_SET_A) begin
			flags_a_q <= flags_a_q | wbits_a;
		end else if (wr_ok && reg_sel == PWP_R_CLR_A) begin
			flags_a_q <= flags_a_q & ~wbits_a;
		end
	end

	// Group C protection flags
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flags_c_q <= RST_C & VALID_C;
		end else if (wr_ok && reg_sel == PWP_R_SET_C) begin
			flags_c_q <= flags_c_q | wbits_c;
		end else if (wr_ok && reg_sel == PWP_R_CLR_C) begin
			flags_c_q <= flags_c_q & ~wbits_c;
		end
	end

	// Read data captured in the setup phase; flags cannot move before access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= '0;
		end else if (rd_setup) begin
			case (reg_sel)
				PWP_R_SET_A, PWP_R_CLR_A: begin
					prdata_q <= (flags_a_q & VALID_A) | (RST_A & ~VALID_A);
				end
				PWP_R_SET_C, PWP_R_CLR_C: begin
					prdata_q <= (flags_c_q & VALID_C) | (RST_C & ~VALID_C);
				end
				PWP_R_STAT: begin
					prdata_q <= {{(DATA_W-EV_W){1'b0}}, ev_stat_q};
				end
				PWP_R_MASK: begin
					prdata_q <= {{(DATA_W-EV_W){1'b0}}, ev_mask_q};
				end
				default: begin
					prdata_q <= '0;
				end
			endcase
		end
	end

	// Read data leaves straight from the flop, so no decode glitches reach the bus
	assign prdata = prdata_q;

	// Guard port: a peripheral write is let through only when unprotected
	assign guard_flag     = guard_wr_group ? flags_c_q[guard_wr_bit] : flags_a_q[guard_wr_bit];
	assign guard_wr_allow = guard_wr_valid & ~guard_flag;

	// Error answer to the blocked peripheral write, one cycle later
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			guard_err_q <= 1'b0;
		end else begin
			guard_err_q <= guard_wr_valid & guard_flag;
		end
	end

	// Registered so the error never loops back into the attempt's own cycle
	assign guard_wr_error = guard_err_q;

	// Events and write-one-to-clear; a new event beats a same-cycle clear
	assign ev_set[EV_BLOCKED]  = guard_wr_valid & guard_flag;
	assign ev_set[EV_DBL_SET]  = wr_acc & dbl_set;
	assign ev_set[EV_DBL_CLR]  = wr_acc & dbl_clr;
	assign ev_set[EV_UNMAPPED] = psel & penable & unmapped;
	assign ev_clr = (wr_acc && reg_sel == PWP_R_STAT) ? wbits[EV_W-1:0] : '0;

	// Sticky status; losing an event to a racing clear would hide it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ev_stat_q <= RST_EV;
		end else begin
			ev_stat_q <= (ev_stat_q & ~ev_clr) | ev_set;
		end
	end

	// Mask register, byte lane 0 only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ev_mask_q <= RST_EV;
		end else if (wr_acc && reg_sel == PWP_R_MASK) begin
			ev_mask_q <= (ev_mask_q & ~lane_mask[EV_W-1:0]) | wbits[EV_W-1:0];
		end
	end

	// Level interrupt while any unmasked event stands
	assign irq = |(ev_stat_q & ev_mask_q);

	// Checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	chk_zero_wait: assert property (
		psel && penable |-> pready && !$past(psel && penable && !pready))
		else $error("access phase stretched");

	chk_lane_keep: assert property (
		wr_acc && reg_sel == PWP_R_SET_C && !pstrb[1]
		|=> flags_c_q[15:8] == $past(flags_c_q[15:8]))
		else $error("disabled lane changed");

	chk_zero_nochange: assert property (
		wr_acc && (reg_sel == PWP_R_CLR_C || reg_sel == PWP_R_SET_A) && pwdata == '0
		|=> $stable(flags_c_q) && $stable(flags_a_q))
		else $error("zero write changed flags");

	chk_clear_takes: assert property (
		wr_acc && !pslverr && reg_sel == PWP_R_CLR_C
		|=> (flags_c_q & $past(wbits_c)) == '0)
		else $error("clear side did not unprotect");

	chk_group_a_read: assert property (
		psel && penable && !pwrite && reg_sel == PWP_R_SET_A
		|-> prdata == ((flags_a_q & VALID_A) | (RST_A & ~VALID_A)))
		else $error("group A read mismatch");

	chk_group_c_fixed: assert property (
		psel && penable && !pwrite && reg_sel == PWP_R_CLR_C
		|-> (prdata & ~VALID_C) == (RST_C & ~VALID_C))
		else $error("group C unassigned bits wrong");

	chk_blocked_write: assert property (
		guard_wr_valid && guard_flag
		|-> !guard_wr_allow ##1 guard_wr_error ##1 ev_stat_q[EV_BLOCKED] || $past(ev_clr[EV_BLOCKED]))
		else $error("protected write not refused");

	chk_set_takes: assert property (
		wr_acc && !pslverr && reg_sel == PWP_R_SET_A
		|=> (flags_a_q & $past(wbits_a)) == $past(wbits_a))
		else $error("set side did not protect");

	chk_double_err: assert property (
		wr_acc && reg_sel == PWP_R_SET_C && |(wbits_c & flags_c_q)
		|-> pslverr ##1 $stable(flags_c_q))
		else $error("double protect not refused");

	chk_unassigned: assert property (
		(flags_a_q & ~VALID_A) == '0 && (flags_c_q & ~VALID_C) == '0)
		else $error("unassigned bit holds state");

	chk_irq_level: assert property (
		|(ev_stat_q & ev_mask_q) |-> irq)
		else $error("interrupt missing");

	// Flag updates on the bus side
	chk_err_dropped: assert property (
		wr_acc && pslverr
		|=> $stable(flags_a_q) && $stable(flags_c_q))
		else $error("erroring write changed flags");

	chk_clr_a_takes: assert property (
		wr_acc && !pslverr && reg_sel == PWP_R_CLR_A
		|=> (flags_a_q & $past(wbits_a)) == '0)
		else $error("group A clear did not unprotect");

	chk_set_c_takes: assert property (
		wr_acc && !pslverr && reg_sel == PWP_R_SET_C
		|=> (flags_c_q & $past(wbits_c)) == $past(wbits_c))
		else $error("group C set did not protect");

	chk_lane_keep_a: assert property (
		wr_acc && reg_sel == PWP_R_SET_A && !pstrb[0]
		|=> $stable(flags_a_q))
		else $error("group A changed without its lane");

	// Both sides of a group read the same vector; misaligned accesses answer with an error
	chk_read_same_a: assert property (
		psel && penable && !pwrite && reg_sel == PWP_R_CLR_A
		|-> prdata == ((flags_a_q & VALID_A) | (RST_A & ~VALID_A)))
		else $error("group A clear side read mismatch");

	chk_read_same_c: assert property (
		psel && penable && !pwrite && reg_sel == PWP_R_SET_C
		|-> prdata == ((flags_c_q & VALID_C) | (RST_C & ~VALID_C)))
		else $error("group C set side read mismatch");

	chk_misaligned_err: assert property (
		psel && penable && paddr[1:0] != 2'b00
		|-> pslverr ##1 ev_stat_q[EV_UNMAPPED])
		else $error("misaligned access not refused");

	// Guard port answers
	chk_guard_quiet: assert property (
		guard_wr_allow |=> !guard_wr_error)
		else $error("allowed write answered with error");

	chk_err_pulse: assert property (
		guard_wr_error |-> $past(guard_wr_valid && guard_flag))
		else $error("error pulse without blocked write");

	// Status and interrupt
	chk_event_sticky: assert property (
		ev_set != '0 |=> (ev_stat_q & $past(ev_set)) == $past(ev_set))
		else $error("event lost to a clear");

	chk_irq_cause: assert property (
		$rose(irq) |-> $past(|(ev_set & ev_mask_q)) || $past(wr_acc && reg_sel == PWP_R_MASK))
		else $error("interrupt rose without cause");

	cov_protect_then_clear: cover property (
		wr_ok && reg_sel == PWP_R_SET_A ##[1:20] wr_ok && reg_sel == PWP_R_CLR_A);
	cov_double_protect: cover property (wr_acc && dbl_set);
	cov_blocked: cover property (guard_wr_valid && guard_flag);
	cov_byte_write: cover property (wr_ok && pstrb == 4'h2);
	cov_misaligned: cover property (psel && penable && paddr[1:0] != 2'b00);

endmodule

`default_nettype wire

// >>> design/pwp_pkg.sv
// Constants for the peripheral write-protection controller.
// Assumes an APB4 master with 32-bit data and byte strobes.
package pwp_pkg;
	localparam int          ADDR_W        = 8;
	localparam int          DATA_W        = 32;
	localparam int          EV_W          = 4;
	// Register byte offsets
	localparam logic [7:0]  OFF_CLR_C     = 8'h00;
	localparam logic [7:0]  OFF_SET_A     = 8'h04;
	localparam logic [7:0]  OFF_CLR_A     = 8'h08;
	localparam logic [7:0]  OFF_SET_C     = 8'h0C;
	localparam logic [7:0]  OFF_EV_STAT   = 8'h10;
	localparam logic [7:0]  OFF_EV_MASK   = 8'h14;
	// Reset values
	localparam logic [31:0] RST_A         = 32'h00000000;
	localparam logic [31:0] RST_C         = 32'h00800000;
	localparam logic [3:0]  RST_EV        = 4'h0;
	// Bits that carry a peripheral in each group
	localparam logic [31:0] VALID_A       = 32'h0000007E;
	localparam logic [31:0] VALID_C       = 32'h000FFFFE;
	// Group A peripheral positions
	localparam int          POWER_MANAGER_BIT   = 1;
	localparam int          SYSTEM_CONTROL_BIT  = 2;
	localparam int          CLOCK_GENERATOR_BIT = 3;
	localparam int          WATCHDOG_BIT        = 4;
	localparam int          RTC_BIT             = 5;
	localparam int          EXT_INTERRUPT_CTRL_BIT = 6;
	// Group C peripheral positions
	localparam int          EVENT_SYSTEM_BIT    = 1;
	localparam int          SERIAL_UNIT_LSB     = 2;
	localparam int          TIMER_UNIT_LSB      = 8;
	localparam int          ADC_BIT             = 16;
	localparam int          ANALOG_COMPARATOR_BIT = 17;
	localparam int          DAC_BIT             = 18;
	localparam int          TOUCH_CONTROLLER_BIT = 19;
	// Event status bit positions
	localparam int          EV_BLOCKED    = 0;
	localparam int          EV_DBL_SET    = 1;
	localparam int          EV_DBL_CLR    = 2;
	localparam int          EV_UNMAPPED   = 3;
	// Register decode result
	typedef enum logic [2:0] {
		PWP_R_NONE  = 3'b000,
		PWP_R_CLR_C = 3'b001,
		PWP_R_SET_A = 3'b010,
		PWP_R_CLR_A = 3'b011,
		PWP_R_SET_C = 3'b100,
		PWP_R_STAT  = 3'b101,
		PWP_R_MASK  = 3'b110
	} pwp_reg_t;
endpackage

// >>> dv/pwp_cpu_model.sv
// Processor-side model issuing APB4 reads and writes to the controller.
// Assumes pclk from the bench; the slave may stretch the access phase.
`timescale 1ns/100ps
`default_nettype none
module pwp_cpu_model
	import pwp_pkg::*;
(
	input  wire logic              pclk,
	output logic                   psel,
	output logic                   penable,
	output logic                   pwrite,
	output logic      [ADDR_W-1:0] paddr,
	output logic      [DATA_W-1:0] pwdata,
	output logic      [3:0]        pstrb,
	input  wire logic [DATA_W-1:0] prdata,
	input  wire logic              pready,
	input  wire logic              pslverr
);
	int timeouts = 0;
	int last_wait = 0;
	// Idle bus from time zero
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h00000000;
		pstrb = 4'h0;
	end
	// One transfer; afterwards address and write data turn to junk so stale data never helps
	task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
		input logic [3:0] s, output logic [DATA_W-1:0] rd, output logic er);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 64);
		if (n >= 64)
			timeouts++;
		last_wait = n;
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		paddr <= ~a;
		pwdata <= ~d;
	endtask
endmodule
`default_nettype wire

// >>> dv/tb_top.sv
// Self-checking bench: register model with W1S/W1C groups and event status.
// Assumes the CPU model as APB master and the bench driving the guard port.
`timescale 1ns/100ps
`default_nettype none
module tb_top
	import pwp_pkg::*;
;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	wire         psel, penable, pwrite, pready, pslverr, allow, gerr, irq;
	wire  [7:0]  paddr;
	wire  [31:0] pwdata, prdata;
	wire  [3:0]  pstrb;
	logic        gv = 1'b0, gg = 1'b0;
	logic [4:0]  gb = 5'h00;
	logic [31:0] fa = RST_A, fc = 32'h00000000, seed = 32'h00014DC9;
	logic [3:0]  st = RST_EV, mk = RST_EV;
	int          fails = 0, total_checks = 0;

	always #12.5 pclk = ~pclk;

	pwp_cpu_model u_cpu (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr));
	pwp_ctrl u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .guard_wr_valid(gv), .guard_wr_group(gg),
		.guard_wr_bit(gb), .guard_wr_allow(allow), .guard_wr_error(gerr), .irq(irq));

	function automatic logic [31:0] xs(input logic [31:0] x);
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	function automatic logic mapped(input logic [7:0] a);
		return a inside {OFF_CLR_C, OFF_SET_A, OFF_CLR_A, OFF_SET_C, OFF_EV_STAT, OFF_EV_MASK};
	endfunction
	// Expected read value; bit 23 of group C is a constant one
	function automatic logic [31:0] mrd(input logic [7:0] a);
		case (a)
			OFF_CLR_C, OFF_SET_C: return fc | RST_C;
			OFF_SET_A, OFF_CLR_A: return fa;
			OFF_EV_STAT: return {28'h0000000, st};
			OFF_EV_MASK: return {28'h0000000, mk};
			default: return 32'h00000000;
		endcase
	endfunction
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fails++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic give_verdict();
		fails += u_cpu.timeouts;
		$display("Checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic rd(input logic [7:0] a);
		logic [31:0] v;
		logic        e;
		u_cpu.xfer(1'b0, a, 32'h00000000, 4'h0, v, e);
		if (u_cpu.timeouts > 0)
			give_verdict();
		chk("prdata", v, mrd(a));
		chk("rd_err", {31'h0, e}, {31'h0, ~mapped(a)});
		chk("rd_cycles", u_cpu.last_wait, 32'h00000001);
		if (!mapped(a))
			st[EV_UNMAPPED] = 1'b1;
	endtask
	// Whole write is dropped on error, so the model only updates when clean
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		logic [31:0] v, m, ones;
		logic        e, x;
		m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
		ones = d & m & ((a == OFF_SET_A || a == OFF_CLR_A) ? VALID_A : VALID_C);
		x = ~mapped(a);
		case (a)
			OFF_SET_A: x = |(ones & fa);
			OFF_CLR_A: x = |(ones & ~fa);
			OFF_SET_C: x = |(ones & fc);
			OFF_CLR_C: x = |(ones & ~fc);
			OFF_EV_STAT: st = st & ~(d[3:0] & m[3:0]);
			OFF_EV_MASK: mk = s[0] ? d[3:0] : mk;
			default: ;
		endcase
		if (!x && a == OFF_SET_A) fa = fa | ones;
		if (!x && a == OFF_CLR_A) fa = fa & ~ones;
		if (!x && a == OFF_SET_C) fc = fc | ones;
		if (!x && a == OFF_CLR_C) fc = fc & ~ones;
		if (x)
			st[(a == OFF_SET_A || a == OFF_SET_C) ? EV_DBL_SET :
				(mapped(a) ? EV_DBL_CLR : EV_UNMAPPED)] = 1'b1;
		u_cpu.xfer(1'b1, a, d, s, v, e);
		if (u_cpu.timeouts > 0)
			give_verdict();
		chk("wr_err", {31'h0, e}, {31'h0, x});
		chk("wr_cycles", u_cpu.last_wait, 32'h00000001);
	endtask
	task automatic guard(input logic g, input logic [4:0] b);
		logic p;
		p = g ? fc[b] : fa[b];
		@(posedge pclk);
		gv <= 1'b1;
		gg <= g;
		gb <= b;
		#1;
		chk("allow", {31'h0, allow}, {31'h0, ~p});
		@(posedge pclk);
		gv <= 1'b0;
		#1;
		chk("guard_err", {31'h0, gerr}, {31'h0, p});
		st[EV_BLOCKED] = st[EV_BLOCKED] | p;
	endtask
	task automatic irqchk();
		@(posedge pclk);
		#1;
		chk("irq", {31'h0, irq}, {31'h0, |(st & mk)});
	endtask

	// Hang guard: running out counts as a mismatch
	initial begin
		#500000;
		fails++;
		give_verdict();
	end
	// Main sequence
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 24; i += 4)
			rd(8'(i));
		wr(OFF_SET_A, 32'h000000FF, 4'h1);
		rd(OFF_CLR_A);
		wr(OFF_SET_A, 32'h00000010, 4'h1);
		wr(OFF_SET_A, 32'hFFFFFF00, 4'hE);
		wr(OFF_SET_C, 32'hFFFFFFFF, 4'h2);
		wr(OFF_SET_C, 32'h00FF00FF, 4'h4);
		wr(OFF_CLR_C, 32'h00000000, 4'hF);
		wr(OFF_CLR_C, 32'h0000F000, 4'h3);
		wr(OFF_CLR_C, 32'h00001000, 4'h2);
		rd(OFF_SET_C);
		rd(OFF_CLR_C);
		wr(OFF_SET_C, 32'h00000100, 4'h2);
		wr(OFF_CLR_A, 32'h00000010, 4'h1);
		irqchk();
		wr(OFF_EV_MASK, 32'h00000007, 4'h1);
		irqchk();
		for (int i = 0; i < 16; i++) begin
			seed = xs(seed);
			guard(seed[0], seed[0] ? 5'(seed[8:4] % 19 + 1) : 5'(seed[8:4] % 6 + 1));
		end
		rd(OFF_EV_STAT);
		irqchk();
		wr(OFF_EV_STAT, 32'h0000000F, 4'h1);
		irqchk();
		wr(8'h20, 32'h00000001, 4'hF);
		rd(8'h06);
		rd(OFF_EV_STAT);
		rd(8'h18);
		give_verdict();
	end
endmodule
`default_nettype wire
